// ==== core/lps_device.sv ====
// lcd driver end: power-save flag and what it freezes
`default_nettype none
module lps_device
	import lps_pkg::*;
#(
	parameter int unsigned CHIP_IDX = 0
) (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	lps_if.dev        bus,
	input  wire logic i_osc_run,
	output logic      o_osc_en,
	output logic      o_supply_en,
	output logic      o_scan_en,
	output logic      o_levels_at_vdd,
	output logic      o_outputs_at_vdd,
	output logic      o_all_points,
	output logic      o_power_save,
	output logic      o_oscillator_output_pin_o,
	output logic      o_oscillator_output_pin_oe_n,
	output logic      o_ext_clk_gated,
	output logic [4:0] o_contrast,
	output logic      o_duty_ext,
	output logic      o_standing_current
);
	lps_dev_t s_q, s_d;
	logic     rst_sync_q;
	logic     take;
	// pin reset combined with system reset, caught by a clocked stage
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_sync_q <= 1'b0;
		end else begin
			rst_sync_q <= bus.rst_pin_n;
		end
	end
	assign take = bus.cmd_valid && !bus.cs_n[CHIP_IDX];
	// command decode
	always_comb begin
		s_d = s_q;
		if (take && s_q.cont_pend) begin
			s_d.contrast  = bus.cmd[4:0];
			s_d.cont_pend = 1'b0;
		end else if (take) begin
			case (bus.cmd)
				LPS_CMD_DISP_ON: begin
					s_d.disp_on = 1'b1;
					s_d.save    = 1'b0;
				end
				LPS_CMD_DISP_OFF: s_d.disp_on = 1'b0;
				LPS_CMD_ALL_ON: begin
					s_d.all_on = 1'b1;
					if (!s_q.disp_on) begin
						s_d.save = 1'b1;
					end
				end
				LPS_CMD_ALL_OFF: begin
					s_d.all_on = 1'b0;
					s_d.save   = 1'b0;
				end
				LPS_CMD_SUPPLY_ON: begin
					s_d.supply_on   = 1'b1;
					s_d.supply_pend = 1'b1;
				end
				LPS_CMD_SUPPLY_OFF: begin
					s_d.supply_on   = 1'b0;
					s_d.supply_pend = 1'b0;
				end
				LPS_CMD_SUPPLY_DONE: s_d.supply_pend = 1'b0;
				LPS_CMD_DUTY1_ON: s_d.duty_ext = 1'b1;
				LPS_CMD_DUTY1_OFF: s_d.duty_ext = 1'b0;
				LPS_CMD_CONTRAST: s_d.cont_pend = 1'b1;
				default: s_d = s_q;
			endcase
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q <= '0;
		end else if (!rst_sync_q) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	// settings kept; only gates follow save
	always_comb begin
		o_power_save                 = s_q.save;
		o_osc_en                     = !s_q.save && i_osc_run;
		o_supply_en                  = !s_q.save && s_q.supply_on;
		o_scan_en                    = !s_q.save && s_q.disp_on;
		o_outputs_at_vdd             = s_q.save;
		o_levels_at_vdd              = s_q.save;
		o_ext_clk_gated              = !s_q.save && bus.ext_clk;
		o_oscillator_output_pin_o    = !s_q.save && i_osc_run;
		o_oscillator_output_pin_oe_n = s_q.save;
		o_all_points                 = s_q.all_on;
		o_contrast                   = s_q.contrast;
		o_duty_ext                   = s_q.duty_ext;
		o_standing_current           = s_q.supply_pend;
	end
endmodule : lps_device
`default_nettype wire

// ==== core/lps_host.sv ====
// host end: issues power sequences in legal order
`default_nettype none
module lps_host
	import lps_pkg::*;
#(
	parameter int unsigned PWRUP_CYC = LPS_PWRUP_CYC,
	parameter int unsigned DECAY_CYC = LPS_DECAY_CYC
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	lps_if.host             bus,
	input  wire logic [2:0] i_seq,
	input  wire logic       i_seq_valid,
	input  wire logic [1:0] i_chip,
	input  wire logic       i_use_duty_ext,
	output logic            o_busy,
	output logic            o_ext_supply_en,
	output logic            o_divider_en,
	output logic            o_ext_com_nonsel,
	output logic            o_logic_supply_off
);
	typedef struct packed {
		lps_hstate_t         st;
		lps_seq_t            seq;
		logic [3:0]          step;
		logic [LPS_CNT_W-1:0] cnt;
		logic [7:0]          cmd;
		logic                vld;
		logic [1:0]          cs_n;
		logic                ext_sup;
		logic                nonsel;
		logic                off;
		logic                rst_n;
		logic                duty;
	} lps_host_t;
	lps_host_t h_q, h_d;
	// save and power-down both end by entering power save
	function automatic logic lps_is_save(input lps_seq_t sq);
		return (sq == LPS_SEQ_SAVE) || (sq == LPS_SEQ_PDOWN);
	endfunction : lps_is_save
	// setup and wake both wait for the supplies before sending
	function automatic logic lps_is_power_up(input lps_seq_t sq);
		return (sq == LPS_SEQ_SETUP) || (sq == LPS_SEQ_WAKE);
	endfunction : lps_is_power_up
	// next command of a sequence, 8'h00 marks its end
	function automatic logic [7:0] lps_step_cmd(input lps_seq_t sq, input logic [3:0] n, input logic duty);
		logic [7:0] c;
		logic [3:0] m;
		c = 8'h00;
		// without the extra common the duty step drops out, later steps move up by one
		m = (duty || n == 4'h0) ? n : n + 4'h1;
		case (sq)
			LPS_SEQ_SETUP, LPS_SEQ_WAKE: begin
				case (m)
					4'h0: c = LPS_CMD_ALL_OFF;
					4'h1: c = LPS_CMD_DUTY1_ON;
					4'h2: c = LPS_CMD_CONTRAST;
					4'h3: c = LPS_CMD_SUPPLY_ON;
					4'h4: c = LPS_CMD_SUPPLY_DONE;
					4'h5: c = LPS_CMD_DISP_ON;
					default: c = 8'h00;
				endcase
			end
			LPS_SEQ_SAVE, LPS_SEQ_PDOWN: begin
				case (m)
					4'h0: c = LPS_CMD_DISP_OFF;
					4'h1: c = LPS_CMD_DUTY1_OFF;
					4'h2: c = LPS_CMD_ALL_ON;
					default: c = 8'h00;
				endcase
			end
			LPS_SEQ_REFR: c = (n == 4'h0) ? LPS_CMD_DISP_ON : 8'h00;
			default: c = 8'h00;
		endcase
		return c;
	endfunction : lps_step_cmd
	// sequencer: one command every second cycle, data byte after its opcode
	always_comb begin
		h_d = h_q;
		h_d.vld = 1'b0;
		case (h_q.st)
			LPS_H_IDLE: begin
				if (i_seq_valid && i_seq != LPS_SEQ_NONE) begin
					h_d.seq  = lps_seq_t'(i_seq);
					h_d.step = 4'h0;
					h_d.duty = i_use_duty_ext;
					h_d.cs_n = ~(2'h1 << i_chip[0]);
					h_d.rst_n = !(lps_seq_t'(i_seq) == LPS_SEQ_SETUP && h_q.seq != LPS_SEQ_SAVE);
					h_d.off  = 1'b0;
					h_d.cnt  = '0;
					h_d.st   = lps_is_power_up(lps_seq_t'(i_seq)) ? LPS_H_WAIT : LPS_H_SEQ;
					if (lps_is_save(lps_seq_t'(i_seq))) begin
						h_d.nonsel = 1'b1;
					end
				end
			end
			LPS_H_WAIT: begin
				h_d.cnt = h_q.cnt + 1'b1;
				if (h_q.cnt == LPS_CNT_W'(PWRUP_CYC - 1)) begin
					h_d.st      = LPS_H_SEQ;
					h_d.ext_sup = 1'b1;
					h_d.nonsel  = 1'b0;
					h_d.rst_n   = 1'b1; // reset pin released as supplies come up
				end
			end
			LPS_H_SEQ: begin
				h_d.st = LPS_H_SEND;
				// supplies stop one cycle after the commons went non-select
				if (lps_is_save(h_q.seq) && h_q.step == 4'h0) begin
					h_d.ext_sup = 1'b0;
				end
				if (h_q.cmd == LPS_CMD_CONTRAST) begin
					h_d.cmd = 8'h00;
					h_d.vld = 1'b1;
				end else if (lps_step_cmd(h_q.seq, h_q.step, h_q.duty) == 8'h00) begin
					h_d.cmd = 8'h00;
					h_d.st  = (h_q.seq == LPS_SEQ_PDOWN) ? LPS_H_DECAY : LPS_H_IDLE;
					h_d.cnt = '0;
				end else begin
					h_d.cmd = lps_step_cmd(h_q.seq, h_q.step, h_q.duty);
					h_d.vld = 1'b1;
				end
			end
			LPS_H_SEND: begin
				// an opcode keeps its step until the data byte is out
				if (h_q.cmd != LPS_CMD_CONTRAST) begin
					h_d.step = h_q.step + 4'h1;
				end
				h_d.st = LPS_H_SEQ;
			end
			LPS_H_DECAY: begin
				h_d.cnt = h_q.cnt + 1'b1;
				if (h_q.cnt == LPS_CNT_W'(DECAY_CYC - 1)) begin
					h_d.off = 1'b1;
					h_d.st  = LPS_H_OFF;
				end
			end
			LPS_H_OFF: begin
				// reset pin kept high until unpowered
				h_d.st = LPS_H_IDLE;
			end
			default: h_d.st = LPS_H_IDLE;
		endcase
	end
	// sequencer state register
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			h_q <= '{st: LPS_H_IDLE, seq: LPS_SEQ_NONE, cs_n: 2'h3, rst_n: 1'b1, default: '0};
		end else begin
			h_q <= h_d;
		end
	end
	// port and control outputs straight from the state register, except ext_clk which is tied low
	assign bus.cmd         = h_q.cmd;
	assign bus.cmd_valid   = h_q.vld;
	assign bus.cs_n        = h_q.cs_n;
	assign bus.rst_pin_n   = h_q.rst_n;
	assign bus.ext_clk     = 1'b0;
	assign o_busy          = (h_q.st != LPS_H_IDLE);
	assign o_ext_supply_en = h_q.ext_sup;
	assign o_divider_en    = h_q.ext_sup;
	assign o_ext_com_nonsel   = h_q.nonsel;
	assign o_logic_supply_off = h_q.off;
endmodule : lps_host
`default_nettype wire

// ==== core/lps_if.sv ====
// byte command port joining host and lcd device
`default_nettype none
interface lps_if;
	logic [7:0] cmd;
	logic       cmd_valid;
	logic [1:0] cs_n;
	logic       rst_pin_n;
	logic       ext_clk;
	modport host (output cmd, output cmd_valid, output cs_n, output rst_pin_n, output ext_clk);
	modport dev  (input cmd, input cmd_valid, input cs_n, input rst_pin_n, input ext_clk);
endinterface : lps_if
`default_nettype wire

// ==== core/lps_pkg.sv ====
// package of constants and types for the lcd power-save sequencer
`default_nettype none
package lps_pkg;
	// command codes on the byte port
	localparam logic [7:0] LPS_CMD_DISP_OFF    = 8'hAE;
	localparam logic [7:0] LPS_CMD_DISP_ON     = 8'hAF;
	localparam logic [7:0] LPS_CMD_ALL_OFF     = 8'hA4;
	localparam logic [7:0] LPS_CMD_ALL_ON      = 8'hA5;
	localparam logic [7:0] LPS_CMD_SUPPLY_OFF  = 8'h24;
	localparam logic [7:0] LPS_CMD_SUPPLY_ON   = 8'h25;
	localparam logic [7:0] LPS_CMD_SUPPLY_DONE = 8'hED;
	localparam logic [7:0] LPS_CMD_DUTY1_OFF   = 8'hAA;
	localparam logic [7:0] LPS_CMD_DUTY1_ON    = 8'hAB;
	localparam logic [7:0] LPS_CMD_CONTRAST    = 8'h80;
	localparam int unsigned LPS_NUM_CS         = 2;
	// timing
	localparam int unsigned LPS_CLK_HZ         = 125_000_000;
	localparam int unsigned LPS_PWRUP_US       = 5000;
	localparam int unsigned LPS_PWRUP_CYC      = LPS_PWRUP_US * (LPS_CLK_HZ / 1_000_000);
	localparam int unsigned LPS_DECAY_US       = 1000;
	localparam int unsigned LPS_DECAY_CYC      = LPS_DECAY_US * (LPS_CLK_HZ / 1_000_000);
	localparam int unsigned LPS_CNT_W          = 24;
	// host sequencer states, gray along the usual path
	typedef enum logic [3:0] {
		LPS_H_IDLE  = 4'h0,
		LPS_H_WAIT  = 4'h1,
		LPS_H_SEQ   = 4'h3,
		LPS_H_SEND  = 4'h2,
		LPS_H_DECAY = 4'h6,
		LPS_H_OFF   = 4'h7
	} lps_hstate_t;
	// host sequences
	typedef enum logic [2:0] {
		LPS_SEQ_NONE  = 3'h0,
		LPS_SEQ_SETUP = 3'h1,
		LPS_SEQ_SAVE  = 3'h2,
		LPS_SEQ_WAKE  = 3'h3,
		LPS_SEQ_PDOWN = 3'h4,
		LPS_SEQ_REFR  = 3'h5
	} lps_seq_t;
	// device state
	typedef struct packed {
		logic       disp_on;
		logic       all_on;
		logic       save;
		logic       supply_on;
		logic       supply_pend;
		logic       duty_ext;
		logic [4:0] contrast;
		logic       cont_pend;
	} lps_dev_t;
endpackage : lps_pkg
`default_nettype wire

// ==== test/lps_monitor.sv ====
// concurrent checks on the command port and the lcd end's save outputs
`default_nettype none
module lps_monitor
	import lps_pkg::*;
(
	input wire logic       i_clk,
	input wire logic       i_rst_n,
	input wire logic [7:0] i_cmd,
	input wire logic       i_cmd_valid,
	input wire logic [1:0] i_cs_n,
	input wire logic       i_rst_pin_n,
	input wire logic       i_power_save,
	input wire logic       i_osc_en,
	input wire logic       i_supply_en,
	input wire logic       i_scan_en,
	input wire logic       i_outputs_at_vdd,
	input wire logic       i_levels_at_vdd,
	input wire logic       i_osc_pin_oe_n,
	input wire logic [4:0] i_contrast
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	logic sel;
	logic rel;
	logic sup_on;
	logic sup_done;
	logic disp_q;
	// commands seen by the first chip
	assign sel      = i_cmd_valid && !i_cs_n[0];
	assign rel      = sel && (i_cmd == LPS_CMD_DISP_ON || i_cmd == LPS_CMD_ALL_OFF);
	assign sup_on   = sel && i_cmd == LPS_CMD_SUPPLY_ON;
	assign sup_done = sel && i_cmd == LPS_CMD_SUPPLY_DONE;
	// tracks display on or off, cleared by the reset pin too
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			disp_q <= 1'b0;
		end else if (!i_rst_pin_n) begin
			disp_q <= 1'b0;
		end else if (sel && i_cmd == LPS_CMD_DISP_OFF) begin
			disp_q <= 1'b0;
		end else if (sel && i_cmd == LPS_CMD_DISP_ON) begin
			disp_q <= 1'b1;
		end
	end
	a_save_entry: assert property (sel && i_cmd == LPS_CMD_ALL_ON && !disp_q |=> i_power_save)
		else $error("save not entered");
	a_osc_halted: assert property (i_power_save |-> !i_osc_en && !i_supply_en)
		else $error("osc or supply runs in save");
	a_scan_stopped: assert property (i_power_save |-> !i_scan_en && i_outputs_at_vdd)
		else $error("scan runs in save");
	a_osc_pin_hiz: assert property (i_power_save |-> i_osc_pin_oe_n)
		else $error("osc pin driven in save");
	a_mode_kept: assert property (i_power_save |=> $stable(i_contrast))
		else $error("contrast changed in save");
	a_levels_clamped: assert property (i_power_save |-> i_levels_at_vdd)
		else $error("levels not at vdd");
	a_save_release: assert property (rel |=> !i_power_save)
		else $error("save not released");
	a_flag_held: assert property (i_power_save && !rel && i_rst_pin_n |=> i_power_save)
		else $error("save flag dropped");
	a_done_follows: assert property (sup_on |-> ##[1:6] sup_done)
		else $error("no startup complete");
	a_reset_pin_idle: assert property (i_power_save |-> i_rst_pin_n)
		else $error("reset pin pulled in save");
	a_valid_pulse: assert property (i_cmd_valid |=> !i_cmd_valid)
		else $error("command valid too long");
	c_entry: cover property (sel && i_cmd == LPS_CMD_ALL_ON && !disp_q);
	c_release: cover property (i_power_save ##1 !i_power_save);
	c_supply: cover property (sup_on);
endmodule : lps_monitor
`default_nettype wire

// ==== test/lps_sequencer_tb_top.sv ====
// testbench joining host and lcd ends through the command port
`default_nettype none
module lps_sequencer_tb_top
	import lps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [2:0] i_seq = 3'h0;
	logic i_seq_valid = 1'b0;
	logic [1:0] i_chip = 2'h0;
	logic i_use_duty_ext = 1'b0;
	logic o_busy, o_ext_supply_en, o_divider_en, o_ext_com_nonsel, o_logic_supply_off;
	logic o_osc_en, o_supply_en, o_scan_en, o_levels_at_vdd, o_outputs_at_vdd, o_power_save;
	logic o_oscillator_output_pin_oe_n, o_duty_ext, o_standing_current;
	logic o_all_points, o_oscillator_output_pin_o, o_ext_clk_gated;
	logic [4:0] o_contrast;
	int num_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	lps_if bus_if ();
	lps_host #(.PWRUP_CYC(20), .DECAY_CYC(20)) lps_host_inst (.i_clk, .i_rst_n, .bus(bus_if.host), .i_seq,
		.i_seq_valid, .i_chip, .i_use_duty_ext, .o_busy, .o_ext_supply_en, .o_divider_en, .o_ext_com_nonsel,
		.o_logic_supply_off);
	lps_device #(.CHIP_IDX(0)) lps_device_inst (.i_clk, .i_rst_n, .bus(bus_if.dev), .i_osc_run(1'b1), .o_osc_en,
		.o_supply_en, .o_scan_en, .o_levels_at_vdd, .o_outputs_at_vdd, .o_all_points, .o_power_save,
		.o_oscillator_output_pin_o, .o_oscillator_output_pin_oe_n, .o_ext_clk_gated, .o_contrast,
		.o_duty_ext, .o_standing_current);
	lps_monitor lps_monitor_inst (.i_clk, .i_rst_n, .i_cmd(bus_if.cmd), .i_cmd_valid(bus_if.cmd_valid),
		.i_cs_n(bus_if.cs_n), .i_rst_pin_n(bus_if.rst_pin_n), .i_power_save(o_power_save), .i_osc_en(o_osc_en),
		.i_supply_en(o_supply_en), .i_scan_en(o_scan_en), .i_outputs_at_vdd(o_outputs_at_vdd),
		.i_levels_at_vdd(o_levels_at_vdd), .i_osc_pin_oe_n(o_oscillator_output_pin_oe_n), .i_contrast(o_contrast));
	// clock and hang guard
	always #4 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			report_and_stop();
		end
	end
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// one host sequence; poke sends a request while busy
	task automatic run(input logic [2:0] s, input logic [1:0] c, input logic dx, input logic poke);
		int k;
		@(posedge i_clk);
		i_seq <= s;
		i_chip <= c;
		i_use_duty_ext <= dx;
		i_seq_valid <= 1'b1;
		@(posedge i_clk);
		i_seq_valid <= 1'b0;
		k = 0;
		do begin
			@(posedge i_clk);
			i_seq <= 3'h4;
			i_seq_valid <= poke && k == 3;
			#1;
			k++;
		end while (o_busy === 1'b1 && k < 800);
		// a sequence that never finishes counts as a mismatch
		if (o_busy !== 1'b0) begin
			num_errors++;
			report_and_stop();
		end
		$display("sequence %0d done", s);
	endtask : run
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (6) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		#1;
		chk("save", o_power_save, 0);
		run(3'h1, 2'h0, 1'b0, 1'b0);
		chk("scan", o_scan_en, 1);
		chk("stand", o_standing_current, 0);
		chk("contr", o_contrast, 0);
		chk("oscp", o_oscillator_output_pin_o, 1);
		chk("allp", o_all_points, 0);
		run(3'h5, 2'h0, 1'b0, 1'b0);
		chk("scan", o_scan_en, 1);
		// save entry and what it freezes
		run(3'h2, 2'h0, 1'b0, 1'b0);
		chk("save", o_power_save, 1);
		chk("osc", {o_osc_en, o_supply_en}, 0);
		chk("out", {o_scan_en, o_outputs_at_vdd}, 1);
		chk("hiz", o_oscillator_output_pin_oe_n, 1);
		chk("oscp", {o_oscillator_output_pin_o, o_ext_clk_gated}, 0);
		chk("allp", o_all_points, 1);
		chk("lvl", o_levels_at_vdd, 1);
		chk("div", o_divider_en, 0);
		chk("esup", o_ext_supply_en, 0);
		chk("nsel", o_ext_com_nonsel, 1);
		// wake with extra common, power-down refused while busy
		run(3'h3, 2'h0, 1'b1, 1'b1);
		chk("save", o_power_save, 0);
		chk("duty", o_duty_ext, 1);
		chk("loff", o_logic_supply_off, 0);
		// settings survive save
		run(3'h2, 2'h0, 1'b0, 1'b0);
		chk("duty", o_duty_ext, 1);
		// setup straight after save must not pulse the reset pin
		run(3'h1, 2'h0, 1'b0, 1'b0);
		chk("duty", o_duty_ext, 1);
		chk("save", o_power_save, 0);
		// other chip selected leaves this one awake
		run(3'h2, 2'h1, 1'b0, 1'b0);
		chk("save", o_power_save, 0);
		run(3'h4, 2'h0, 1'b0, 1'b0);
		chk("loff", o_logic_supply_off, 1);
		chk("rpin", bus_if.rst_pin_n, 1);
		report_and_stop();
	end
endmodule : lps_sequencer_tb_top
`default_nettype wire
